// >>> rtl/fmcd_decoder.sv
// Utility command decoder: read id, dump, relative seek, lock, perpendicular, invalid
`timescale 1ns/10ps
// Overview of operation
// - Read id keeps the first good identifier field seen on the cylinder.
// - Read id answers status bytes zero to two, then cylinder, head, sector, size.
// - Unknown opcode: no operation, standby, single result byte 80H.
// - Dump shared byte holds sectors per track after a format command.
// - Dump shared byte holds end of track sector after read or write.
// - Command drive select bits are driven out on o_readid_select and o_seek.drive_select.
module fmcd_decoder (
    input  wire logic                     i_clock,
    input  wire logic                     i_rst,
    input  wire logic                     i_cmd_valid,
    input  wire logic [7:0]               i_cmd_byte,
    input  wire logic                     i_res_read,
    input  wire logic                     i_id_valid,
    input  wire fmcd_pkg::fmcd_id_type    i_id,
    input  wire logic                     i_exec_done,
    input  wire fmcd_pkg::fmcd_status_type i_status,
    input  wire fmcd_pkg::fmcd_dump_type  i_dump,
    input  wire fmcd_pkg::fmcd_last_type  i_last_cmd,
    output logic                          o_cmd_ready,
    output logic                          o_res_valid,
    output logic [7:0]                    o_res_byte,
    output logic                          o_readid_start,
    output logic [3:0]                    o_readid_select,
    output logic                          o_seek_start,
    output fmcd_pkg::fmcd_seek_type       o_seek,
    output logic                          o_lock,
    output logic [7:0]                    o_perp_setting,
    output logic                          o_standby
);
    typedef enum logic [2:0] {
        S_OPCODE,
        S_PARAM,
        S_EXEC,
        S_FILL,
        S_RESULT
    } fmcd_state_type;

    typedef enum logic [2:0] {
        C_READID,
        C_DUMP,
        C_RELSEEK,
        C_LOCK,
        C_PERP,
        C_INVALID
    } fmcd_cmd_type;

    localparam logic [3:0] IDX_ONE = 4'h_1;
    fmcd_state_type             state, next_state;
    fmcd_cmd_type               cmd, next_cmd;
    logic [7:0]                 opcode, next_opcode;
    logic [7:0]                 par0, next_par0;
    logic [3:0]                 pcount, next_pcount;
    logic [3:0]                 fill_idx, next_fill_idx;
    logic [3:0]                 res_len, next_res_len;
    logic [3:0]                 rd_idx, next_rd_idx;
    logic                       res_valid, next_res_valid;
    logic                       prime, next_prime;
    fmcd_pkg::fmcd_id_type      id_hold, next_id_hold;
    logic                       id_got, next_id_got;
    logic                       readid_start, next_readid_start;
    logic [3:0]                 readid_select, next_readid_select;
    logic                       seek_start, next_seek_start;
    fmcd_pkg::fmcd_seek_type    seek, next_seek;
    logic                       lock, next_lock;
    logic [7:0]                 perp, next_perp;
    logic                       standby, next_standby;
    logic                       cmd_ready, next_cmd_ready;
    logic [7:0]                 fill_byte;
    logic [7:0]                 mem_rdata;
    // Opcode classification shared by the decode path
    function automatic fmcd_cmd_type classify(input logic [7:0] b);
        if ((b & fmcd_pkg::OPC_RELSEEK_MASK) == fmcd_pkg::OPC_RELSEEK) begin
            return C_RELSEEK;
        end else if (b == fmcd_pkg::OPC_DUMP) begin
            return C_DUMP;
        end else if ((b & fmcd_pkg::OPC_READID_MASK) == fmcd_pkg::OPC_READID) begin
            return C_READID;
        end else if ((b & fmcd_pkg::OPC_LOCK_MASK) == fmcd_pkg::OPC_LOCK) begin
            return C_LOCK;
        end else if (b == fmcd_pkg::OPC_PERP) begin
            return C_PERP;
        end
        return C_INVALID;
    endfunction

    // Parameter byte count per command
    function automatic logic [3:0] param_count(input fmcd_cmd_type c);
        case (c)
            C_RELSEEK: return 4'h_2;
            C_READID:  return 4'h_1;
            C_PERP:    return 4'h_1;
            default:   return 4'h_0;
        endcase
    endfunction

    // Result byte at a given position, chosen per command
    always_comb begin
        fill_byte = fmcd_pkg::ZERO_BYTE;
        case (cmd)
            C_READID: begin
                case (fill_idx)
                    4'h_0:   fill_byte = i_status.status_byte_zero;
                    4'h_1:   fill_byte = i_status.status_byte_one;
                    4'h_2:   fill_byte = i_status.status_byte_two;
                    4'h_3:   fill_byte = id_hold.cylinder;
                    4'h_4:   fill_byte = id_hold.head;
                    4'h_5:   fill_byte = id_hold.sector;
                    default: fill_byte = id_hold.size_code;
                endcase
            end
            C_DUMP: begin
                case (fill_idx)
                    4'h_0:   fill_byte = i_dump.present_cylinder[7:0];
                    4'h_1:   fill_byte = i_dump.present_cylinder[15:8];
                    4'h_2:   fill_byte = i_dump.present_cylinder[23:16];
                    4'h_3:   fill_byte = i_dump.present_cylinder[31:24];
                    4'h_4:   fill_byte = i_dump.step_unload;
                    4'h_5:   fill_byte = i_dump.load_nodma;
                    // Read or write gives end of track, which is also the idle choice
                    4'h_6:   fill_byte = (i_last_cmd == fmcd_pkg::FMCD_LAST_FORMAT) ?
                                         i_dump.sectors_per_track :
                                         i_dump.end_of_track_sector;
                    4'h_7:   fill_byte = {lock, perp[6:0]};
                    4'h_8:   fill_byte = i_dump.config_byte;
                    default: fill_byte = i_dump.precomp_track;
                endcase
            end
            C_LOCK:  fill_byte[fmcd_pkg::BIT_LOCK_ECHO] = lock;
            default: fill_byte = fmcd_pkg::INVALID_RESULT;
        endcase
    end

    fmcd_result_mem #(.DEPTH (16)) fmcd_result_mem_inst (
        .i_clock (i_clock),
        .i_we    (state == S_FILL),
        .i_waddr (fill_idx),
        .i_wdata (fill_byte),
        .i_raddr (next_rd_idx),
        .o_rdata (mem_rdata)
    );

    // Command sequencing next state
    always_comb begin
        next_state         = state;
        next_cmd           = cmd;
        next_opcode        = opcode;
        next_par0          = par0;
        next_pcount        = pcount;
        next_fill_idx      = fill_idx;
        next_res_len       = res_len;
        next_rd_idx        = rd_idx;
        next_res_valid     = res_valid;
        next_prime         = 1'b0;
        next_id_hold       = id_hold;
        next_id_got        = id_got;
        next_readid_start  = 1'b0;
        next_readid_select = readid_select;
        next_seek_start    = 1'b0;
        next_seek          = seek;
        next_lock          = lock;
        next_perp          = perp;
        next_standby       = standby;
        case (state)
            S_OPCODE: begin
                if (i_cmd_valid) begin
                    next_opcode  = i_cmd_byte;
                    next_cmd     = classify(i_cmd_byte);
                    next_pcount  = param_count(classify(i_cmd_byte));
                    next_standby  = (classify(i_cmd_byte) == C_INVALID);
                    next_state    = (next_pcount == 4'h_0) ? S_FILL : S_PARAM;
                    next_fill_idx = 4'h_0;
                    if (classify(i_cmd_byte) == C_LOCK) begin
                        next_lock = i_cmd_byte[fmcd_pkg::BIT_LOCK];
                    end
                    case (classify(i_cmd_byte))
                        C_READID: next_res_len = fmcd_pkg::READID_RES_LEN;
                        C_DUMP:   next_res_len = fmcd_pkg::DUMP_RES_LEN;
                        default:  next_res_len = fmcd_pkg::ONE_RES_LEN;
                    endcase
                end
            end
            S_PARAM: begin
                if (i_cmd_valid) begin
                    next_pcount = pcount - IDX_ONE;
                    if (pcount == param_count(cmd)) begin
                        next_par0 = i_cmd_byte;
                    end
                    if (pcount == IDX_ONE) begin
                        case (cmd)
                            C_READID: begin
                                // Select bits registered and driven out on o_readid_select
                                next_readid_select = i_cmd_byte[3:0];
                                next_readid_start  = 1'b1;
                                next_id_got        = 1'b0;
                                next_state         = S_EXEC;
                            end
                            C_RELSEEK: begin
                                next_seek.direction_in = opcode[fmcd_pkg::BIT_DIR];
                                next_seek.head_select  = par0[2];
                                next_seek.drive_select = par0[1:0];
                                next_seek.relative_cylinder_count = i_cmd_byte;
                                next_seek_start = 1'b1;
                                next_state      = S_OPCODE;
                            end
                            C_PERP: begin
                                next_perp  = i_cmd_byte;
                                next_state = S_OPCODE;
                            end
                            default: next_state = S_OPCODE;
                        endcase
                    end
                end
            end
            S_EXEC: begin
                // Only the first good field is kept; later ones are ignored
                if (i_id_valid && !id_got) begin
                    next_id_hold = i_id;
                    next_id_got  = 1'b1;
                end
                if (i_exec_done) begin
                    next_state    = S_FILL;
                    next_fill_idx = 4'h_0;
                end
            end
            S_FILL: begin
                next_fill_idx = fill_idx + IDX_ONE;
                if (fill_idx + IDX_ONE == res_len) begin
                    next_state  = S_RESULT;
                    next_rd_idx = 4'h_0;
                    next_prime  = 1'b1;
                end
            end
            S_RESULT: begin
                next_res_valid = prime | res_valid;
                if (res_valid && i_res_read) begin
                    next_res_valid = 1'b0;
                    if (rd_idx + IDX_ONE == res_len) begin
                        next_state = S_OPCODE;
                    end else begin
                        next_rd_idx = rd_idx + IDX_ONE;
                        next_prime  = 1'b1;
                    end
                end
            end
            default: next_state = S_OPCODE;
        endcase
        // Ready follows the state being entered, so it can sit in a register
        next_cmd_ready = (next_state == S_OPCODE) || (next_state == S_PARAM);
    end

    // Registers of the sequencer; memory data lags address by one cycle
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state         <= S_OPCODE;
            cmd           <= C_INVALID;
            opcode        <= fmcd_pkg::ZERO_BYTE;
            par0          <= fmcd_pkg::ZERO_BYTE;
            pcount        <= 4'h_0;
            fill_idx      <= 4'h_0;
            res_len       <= 4'h_0;
            rd_idx        <= 4'h_0;
            res_valid     <= 1'b0;
            prime         <= 1'b0;
            id_hold       <= '0;
            id_got        <= 1'b0;
            readid_start  <= 1'b0;
            readid_select <= 4'h_0;
            seek_start    <= 1'b0;
            seek          <= '0;
            lock          <= 1'b0;
            perp          <= fmcd_pkg::ZERO_BYTE;
            standby       <= 1'b0;
            cmd_ready     <= 1'b1;
        end else begin
            state         <= next_state;
            cmd           <= next_cmd;
            opcode        <= next_opcode;
            par0          <= next_par0;
            pcount        <= next_pcount;
            fill_idx      <= next_fill_idx;
            res_len       <= next_res_len;
            rd_idx        <= next_rd_idx;
            res_valid     <= next_res_valid;
            prime         <= next_prime;
            id_hold       <= next_id_hold;
            id_got        <= next_id_got;
            readid_start  <= next_readid_start;
            readid_select <= next_readid_select;
            seek_start    <= next_seek_start;
            seek          <= next_seek;
            lock          <= next_lock;
            perp          <= next_perp;
            standby       <= next_standby;
            cmd_ready     <= next_cmd_ready;
        end
    end

    // Outputs straight from flip-flops
    always_comb begin
        o_cmd_ready     = cmd_ready;
        o_res_valid     = res_valid;
        o_res_byte      = mem_rdata;
        o_readid_start  = readid_start;
        o_readid_select = readid_select;
        o_seek_start    = seek_start;
        o_seek          = seek;
        o_lock          = lock;
        o_perp_setting  = perp;
        o_standby       = standby;
    end
endmodule

// >>> rtl/fmcd_pkg.sv
// Package: opcodes, result layouts, carriers for the utility command decoder
package fmcd_pkg;
    localparam logic [7:0] OPC_RELSEEK_MASK  = 8'h_bf;
    localparam logic [7:0] OPC_RELSEEK       = 8'h_8f;
    localparam logic [7:0] OPC_DUMP          = 8'h_0e;
    localparam logic [7:0] OPC_READID_MASK   = 8'h_bf;
    localparam logic [7:0] OPC_READID        = 8'h_0a;
    localparam logic [7:0] OPC_PERP          = 8'h_12;
    localparam logic [7:0] OPC_LOCK_MASK     = 8'h_7f;
    localparam logic [7:0] OPC_LOCK          = 8'h_14;
    localparam logic [7:0] INVALID_RESULT    = 8'h_80;
    localparam int         BIT_DIR           = 6;
    localparam int         BIT_LOCK          = 7;
    localparam int         BIT_LOCK_ECHO     = 4;
    localparam logic [3:0] READID_RES_LEN    = 4'h_7;
    localparam logic [3:0] DUMP_RES_LEN      = 4'h_a;
    localparam logic [3:0] ONE_RES_LEN       = 4'h_1;
    localparam logic [7:0] ZERO_BYTE         = 8'h_00;

    // Last data command kind, picks the shared dump byte
    typedef enum logic [1:0] {
        FMCD_LAST_OTHER,
        FMCD_LAST_FORMAT,
        FMCD_LAST_RDWR
    } fmcd_last_type;

    // One identifier field as read from the disk
    typedef struct packed {
        logic [7:0] cylinder;
        logic [7:0] head;
        logic [7:0] sector;
        logic [7:0] size_code;
    } fmcd_id_type;

    // Status bytes from the execution engine
    typedef struct packed {
        logic [7:0] status_byte_zero;
        logic [7:0] status_byte_one;
        logic [7:0] status_byte_two;
    } fmcd_status_type;

    // Controller settings returned by the register dump
    typedef struct packed {
        logic [31:0] present_cylinder;
        logic [7:0]  step_unload;
        logic [7:0]  load_nodma;
        logic [7:0]  sectors_per_track;
        logic [7:0]  end_of_track_sector;
        logic [7:0]  config_byte;
        logic [7:0]  precomp_track;
    } fmcd_dump_type;

    // Relative seek order passed to the positioning logic
    typedef struct packed {
        logic       direction_in;
        logic       head_select;
        logic [1:0] drive_select;
        logic [7:0] relative_cylinder_count;
    } fmcd_seek_type;
endpackage

// >>> rtl/fmcd_result_mem.sv
// Result byte store with registered read port
`timescale 1ns/10ps
module fmcd_result_mem #(
    parameter int DEPTH = 16
) (
    input  wire logic                     i_clock,
    input  wire logic                     i_we,
    input  wire logic [$clog2(DEPTH)-1:0] i_waddr,
    input  wire logic [7:0]               i_wdata,
    input  wire logic [$clog2(DEPTH)-1:0] i_raddr,
    output logic      [7:0]               o_rdata
);
    logic [7:0] mem [DEPTH];

    // Plain storage, no reset needed since bytes are written before read
    always_ff @(posedge i_clock) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule

// >>> test/fmcd_decoder_checker.sv
// Port-level assertions for the utility command decoder
`timescale 1ns/10ps
module fmcd_decoder_checker (
    input wire logic                      i_clock,
    input wire logic                      i_rst,
    input wire logic                      i_cmd_valid,
    input wire logic [7:0]                i_cmd_byte,
    input wire logic                      i_res_read,
    input wire logic                      i_exec_done,
    input wire fmcd_pkg::fmcd_status_type i_status,
    input wire fmcd_pkg::fmcd_dump_type   i_dump,
    input wire logic                      o_cmd_ready,
    input wire logic                      o_res_valid,
    input wire logic [7:0]                o_res_byte,
    input wire logic                      o_readid_start,
    input wire logic [3:0]                o_readid_select,
    input wire logic                      o_seek_start,
    input wire fmcd_pkg::fmcd_seek_type   o_seek,
    input wire logic                      o_standby
);
    logic [1:0] left;
    logic [1:0] next_left;
    logic [1:0] cnt;
    logic       rid;
    logic       next_rid;
    logic       take;
    logic       op;
    logic       inv;
    logic       lck;
    // Tracks parameter bytes still owed, so opcode bytes can be told apart
    always_comb begin
        take = i_cmd_valid && o_cmd_ready;
        op = take && (left == 2'h_0);
        lck = (i_cmd_byte & fmcd_pkg::OPC_LOCK_MASK) == fmcd_pkg::OPC_LOCK;
        inv = 1'h_0;
        if ((i_cmd_byte & fmcd_pkg::OPC_RELSEEK_MASK) == fmcd_pkg::OPC_RELSEEK) begin
            cnt = 2'h_2;
        end else if ((i_cmd_byte & fmcd_pkg::OPC_READID_MASK) == fmcd_pkg::OPC_READID
                     || i_cmd_byte == fmcd_pkg::OPC_PERP) begin
            cnt = 2'h_1;
        end else begin
            cnt = 2'h_0;
            inv = !lck && (i_cmd_byte != fmcd_pkg::OPC_DUMP);
        end
        next_left = op ? cnt : (take ? left - 2'h_1 : left);
        next_rid = o_readid_start ? 1'h_1 : (i_exec_done ? 1'h_0 : rid);
    end
    // Tracker registers
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            left <= 2'h_0;
            rid <= 1'h_0;
        end else begin
            left <= next_left;
            rid <= next_rid;
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    property p_invalid;
        op && inv |-> ##3 o_res_valid && o_res_byte == fmcd_pkg::INVALID_RESULT;
    endproperty
    a_invalid: assert property (p_invalid) else $error("unknown opcode result wrong");
    property p_standby; op && inv |-> ##[1:3] o_standby; endproperty
    a_standby: assert property (p_standby) else $error("standby not entered");
    property p_wake; op && !inv |-> ##[1:3] !o_standby; endproperty
    a_wake: assert property (p_wake) else $error("standby not left");
    property p_lock_res;
        op && lck |-> ##3 o_res_valid && o_res_byte == {3'h_0, $past(i_cmd_byte[7], 3), 4'h_0};
    endproperty
    a_lock_res: assert property (p_lock_res) else $error("lock echo wrong");
    property p_dump;
        op && i_cmd_byte == fmcd_pkg::OPC_DUMP |-> ##12 o_res_valid
            && o_res_byte == i_dump.present_cylinder[7:0];
    endproperty
    a_dump: assert property (p_dump) else $error("dump first byte wrong");
    property p_seek;
        o_seek_start |-> $past(take) && o_seek.relative_cylinder_count == $past(i_cmd_byte);
    endproperty
    a_seek: assert property (p_seek) else $error("seek count wrong");
    property p_sel;
        o_readid_start |-> $past(take) && o_readid_select == $past(i_cmd_byte[3:0]);
    endproperty
    a_sel: assert property (p_sel) else $error("read id select wrong");
    property p_rid;
        rid && i_exec_done |-> ##9 o_res_valid
            && o_res_byte == $past(i_status.status_byte_zero, 9);
    endproperty
    a_rid: assert property (p_rid) else $error("read id first result wrong");
    property p_drop; o_res_valid && i_res_read |=> !o_res_valid; endproperty
    a_drop: assert property (p_drop) else $error("result not consumed");
endmodule

bind fmcd_decoder fmcd_decoder_checker fmcd_decoder_checker_inst (
    .i_clock(i_clock), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid), .i_cmd_byte(i_cmd_byte),
    .i_res_read(i_res_read), .i_exec_done(i_exec_done), .i_status(i_status),
    .i_dump(i_dump), .o_cmd_ready(o_cmd_ready), .o_res_valid(o_res_valid),
    .o_res_byte(o_res_byte), .o_readid_start(o_readid_start),
    .o_readid_select(o_readid_select), .o_seek_start(o_seek_start), .o_seek(o_seek),
    .o_standby(o_standby)
);

// >>> test/fmcd_decoder_tb.sv
// Self-checking testbench for the utility command decoder
`timescale 1ns/10ps
module fmcd_decoder_tb;
    localparam fmcd_pkg::fmcd_id_type     ID_A = 32'h_1201_0502;
    localparam fmcd_pkg::fmcd_id_type     ID_B = 32'h_1300_0603;
    localparam fmcd_pkg::fmcd_status_type ST   = 24'h_40_0102;
    logic i_clock, i_rst, i_cmd_valid, i_res_read, i_id_valid, i_exec_done, slow;
    logic o_cmd_ready, o_res_valid, o_readid_start, o_seek_start, o_lock, o_standby;
    logic [7:0] i_cmd_byte, o_res_byte, o_perp_setting;
    logic [3:0] o_readid_select;
    fmcd_pkg::fmcd_id_type     i_id;
    fmcd_pkg::fmcd_status_type i_status;
    fmcd_pkg::fmcd_dump_type   i_dump;
    fmcd_pkg::fmcd_last_type   i_last_cmd;
    fmcd_pkg::fmcd_seek_type   o_seek;
    int fails, comparisons;

    fmcd_decoder fmcd_decoder_inst (.i_clock(i_clock), .i_rst(i_rst),
        .i_cmd_valid(i_cmd_valid), .i_cmd_byte(i_cmd_byte), .i_res_read(i_res_read),
        .i_id_valid(i_id_valid), .i_id(i_id), .i_exec_done(i_exec_done),
        .i_status(i_status), .i_dump(i_dump), .i_last_cmd(i_last_cmd),
        .o_cmd_ready(o_cmd_ready), .o_res_valid(o_res_valid), .o_res_byte(o_res_byte),
        .o_readid_start(o_readid_start), .o_readid_select(o_readid_select),
        .o_seek_start(o_seek_start), .o_seek(o_seek), .o_lock(o_lock),
        .o_perp_setting(o_perp_setting), .o_standby(o_standby));
    fmcd_engine_model #(.FIRST(ID_A), .SECOND(ID_B), .STATUS(ST)) fmcd_engine_model_inst (
        .i_clock(i_clock), .i_start(o_readid_start), .i_slow(slow), .o_id(i_id),
        .o_id_valid(i_id_valid), .o_exec_done(i_exec_done), .o_status(i_status));

    // 250 MHz clock
    initial begin
        i_clock = 1'h_0;
        forever #2 i_clock = ~i_clock;
    end
    task results;
        if (fails == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Host byte write: request held until an edge sees ready
    task send(input logic [7:0] b);
        int n;
        @(negedge i_clock);
        i_cmd_valid = 1'h_1;
        i_cmd_byte = b;
        for (n = 0; o_cmd_ready !== 1'h_1 && n < 200; n++) @(negedge i_clock);
        if (n >= 200) fails++;
        @(negedge i_clock);
        i_cmd_valid = 1'h_0;
    endtask
    // Host result read, entered on a falling edge
    task get(input logic [7:0] exp);
        int n;
        for (n = 0; o_res_valid !== 1'h_1 && n < 200; n++) @(negedge i_clock);
        if (n >= 200) fails++;
        chk(o_res_byte, exp);
        i_res_read = 1'h_1;
        @(negedge i_clock);
        i_res_read = 1'h_0;
    endtask
    // Unknown opcodes; a lock byte pushed during the result phase must be refused
    task t_invalid(input logic [7:0] b);
        send(b);
        chk(o_cmd_ready, 1'h_0);
        @(negedge i_clock);
        i_cmd_valid = 1'h_1;
        i_cmd_byte = 8'h_94;
        @(negedge i_clock);
        i_cmd_valid = 1'h_0;
        get(fmcd_pkg::INVALID_RESULT);
        chk(o_standby, 1'h_1);
        chk(o_lock, 1'h_0);
    endtask
    task t_lock(input logic l);
        send({l, 7'h_14});
        get({3'h_0, l, 4'h_0});
        chk(o_lock, l);
        chk(o_standby, 1'h_0);
    endtask
    task t_seek(input logic d, input logic [7:0] c);
        send({1'h_1, d, 6'h_0f});
        send(8'h_05);
        send(c);
        // Start pulse lasts one cycle, so look right after the last byte
        chk(o_seek_start, 1'h_1);
        chk(o_seek, {d, 1'h_1, 2'h_1, c});
    endtask
    task t_perp(input logic [7:0] p);
        send(fmcd_pkg::OPC_PERP);
        send(p);
        chk(o_perp_setting, p);
    endtask
    // Dump after a format, then after a read or write
    task t_dump(input int k);
        logic [7:0] e [10];
        i_last_cmd = fmcd_pkg::fmcd_last_type'(k);
        e = '{8'h_11, 8'h_22, 8'h_33, 8'h_44, 8'h_55, 8'h_66,
              (k == 1) ? 8'h_77 : 8'h_88, 8'h_83, 8'h_99, 8'h_aa};
        send(fmcd_pkg::OPC_DUMP);
        for (int i = 0; i < 10; i++) get(e[i]);
    endtask
    task t_readid(input logic s);
        logic [55:0] e;
        e = {ST, ID_A};
        slow = s;
        send({1'h_0, s, 6'h_0a});
        send(8'h_06);
        @(negedge i_clock);
        chk(o_readid_select, 4'h_6);
        for (int i = 0; i < 7; i++) get(e[55 - 8 * i -: 8]);
    endtask
    // Watchdog well beyond the expected run
    initial begin
        repeat (20000) @(posedge i_clock);
        fails++;
        results();
    end
    initial begin
        fails = 0;
        comparisons = 0;
        i_rst = 1'h_1;
        i_cmd_valid = 1'h_0;
        i_cmd_byte = 8'h_00;
        i_res_read = 1'h_0;
        slow = 1'h_0;
        i_last_cmd = fmcd_pkg::FMCD_LAST_OTHER;
        i_dump = {32'h_4433_2211, 8'h_55, 8'h_66, 8'h_77, 8'h_88, 8'h_99, 8'h_aa};
        repeat (10) @(negedge i_clock);
        i_rst = 1'h_0;
        t_invalid(8'h_07);
        t_invalid(8'h_00);
        t_lock(1'h_0);
        t_lock(1'h_1);
        t_perp(8'h_03);
        t_seek(1'h_0, 8'h_01);
        t_seek(1'h_1, 8'h_ff);
        t_dump(1);
        t_dump(2);
        t_readid(1'h_0);
        t_readid(1'h_1);
        results();
    end
endmodule

// >>> test/fmcd_engine_model.sv
// Behavioural disk-side engine: identifier fields and status for read id
`timescale 1ns/10ps
module fmcd_engine_model #(
    parameter fmcd_pkg::fmcd_id_type     FIRST  = 32'h_0000_0000,
    parameter fmcd_pkg::fmcd_id_type     SECOND = 32'h_0000_0000,
    parameter fmcd_pkg::fmcd_status_type STATUS = 24'h_00_0000
) (
    input  wire logic                      i_clock,
    input  wire logic                      i_start,
    input  wire logic                      i_slow,
    output fmcd_pkg::fmcd_id_type          o_id,
    output logic                           o_id_valid,
    output logic                           o_exec_done,
    output fmcd_pkg::fmcd_status_type      o_status
);
    // Released fields show an inverted pattern so stale data cannot pass
    initial begin
        o_id_valid = 1'h_0;
        o_exec_done = 1'h_0;
        o_id = ~FIRST;
        o_status = ~STATUS;
        forever begin
            @(negedge i_clock);
            if (i_start === 1'h_1) begin
                repeat (i_slow ? 40 : 2) @(negedge i_clock);
                o_id = FIRST;
                o_id_valid = 1'h_1;
                @(negedge i_clock);
                // A later good field follows; only the first may be kept
                o_id = SECOND;
                @(negedge i_clock);
                o_id_valid = 1'h_0;
                o_id = ~SECOND;
                o_status = STATUS;
                o_exec_done = 1'h_1;
                @(negedge i_clock);
                o_exec_done = 1'h_0;
                // Status stays put through the result fill, then is released
                repeat (12) @(negedge i_clock);
                o_status = ~STATUS;
            end
        end
    end
endmodule
